// File: common/rfm_defines.svh
`ifndef RFM_DEFINES_SVH
`define RFM_DEFINES_SVH

// Register subaddresses
`define RFM_ADDR_RESULT_HIGH  3'h0
`define RFM_ADDR_RESULT_MID   3'h1
`define RFM_ADDR_RESULT_LOW   3'h2
`define RFM_ADDR_RATE         3'h3
`define RFM_ADDR_MISC         3'h4
`define RFM_ADDR_REFERENCE_CLOCK_INPUT_CTRL  3'h5
`define RFM_ADDR_RESTART_CTRL 3'h6
`define RFM_ADDR_OUTPUT_CTRL  3'h7

// Reset values
`define RFM_REFERENCE_CLOCK_INPUT_CTRL_RST   8'h00
`define RFM_RESTART_CTRL_RST  8'h00
`define RFM_OUTPUT_CTRL_RST   8'h00

// Field positions of the status byte
`define RFM_MISC_COARSE_LSB   0
`define RFM_MISC_LOCK_LOST    1
`define RFM_MISC_MEAS_DONE    2

// Result layout
`define RFM_RESULT_W          23
`define RFM_HIGH_MSB          22
`define RFM_HIGH_LSB          16
`define RFM_MID_LSB           8

// Measurement window base exponent
`define RFM_WINDOW_BASE_LOG2  14

`endif

// File: common/rfm_pkg.sv
package rfm_pkg;

    typedef struct packed {
        logic [1:0] range;
        logic [3:0] ratio;
        logic       fine_en;
        logic       lock_en;
    } rfm_reference_clock_input_ctrl_t;

    typedef struct packed {
        logic [1:0] rsv_hi;
        logic       acq_restart;
        logic       rsv_mid;
        logic       meas_restart;
        logic [2:0] rsv_lo;
    } rfm_restart_ctrl_t;

    typedef struct packed {
        logic [4:0] rsv_hi;
        logic       los_pol;
        logic [1:0] rsv_lo;
    } rfm_output_ctrl_t;

    // Controls handed to the analog acquisition loop
    typedef struct packed {
        logic       lock_mode;
        logic [1:0] range;
        logic [3:0] ratio;
        logic       lock_cmd;
        logic       acq_start;
    } rfm_loop_ctl_t;

    typedef enum logic [0:0] {
        RFM_MEAS_IDLE,
        RFM_MEAS_RUN
    } rfm_meas_state_t;

endpackage

// File: hw/rfm_rate_meter.sv
`timescale 1ns/1ps
`include "rfm_defines.svh"

module rfm_rate_meter #(
    parameter int PRESC_LOG2 = 6
) (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     srst_i,
    // Control
    input  wire logic                     en_i,
    input  wire logic                     start_i,
    input  wire logic [1:0]               range_i,
    // Events
    input  wire logic                     ref_tick_i,
    input  wire logic                     data_tick_i,
    // Result
    output logic                          done_o,
    output logic [`RFM_RESULT_W-1:0]      result_o
);

    localparam int WIN_W = `RFM_WINDOW_BASE_LOG2 + 3 + PRESC_LOG2 + 1;

    rfm_pkg::rfm_meas_state_t    state_q;
    logic [WIN_W-1:0]            win_cnt_q;
    logic [WIN_W-1:0]            win_last;
    logic [`RFM_RESULT_W-1:0]    data_cnt_q;

    // Window spans 2^(14+range) reference periods times the data prescale,
    // so the data count lands directly in result units
    assign win_last = (WIN_W'(1) << (`RFM_WINDOW_BASE_LOG2 + int'(range_i)
                      + PRESC_LOG2)) - WIN_W'(1);

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_q    <= rfm_pkg::RFM_MEAS_IDLE;
            win_cnt_q  <= '0;
            data_cnt_q <= '0;
            done_o     <= 1'b0;
            result_o   <= '0;
        end
        else
        begin
            done_o <= 1'b0;
            case (state_q)
                rfm_pkg::RFM_MEAS_IDLE:
                begin
                    if (start_i && en_i)
                    begin
                        win_cnt_q  <= '0;
                        data_cnt_q <= '0;
                        state_q    <= rfm_pkg::RFM_MEAS_RUN;
                    end
                end
                rfm_pkg::RFM_MEAS_RUN:
                begin
                    if (!en_i)
                        state_q <= rfm_pkg::RFM_MEAS_IDLE;
                    else if (start_i)
                    begin
                        win_cnt_q  <= '0;
                        data_cnt_q <= '0;
                    end
                    else
                    begin
                        // Saturate rather than wrap on a too-fast data rate
                        if (data_tick_i && !(&data_cnt_q))
                            data_cnt_q <= data_cnt_q + 1'b1;
                        if (ref_tick_i)
                        begin
                            win_cnt_q <= win_cnt_q + 1'b1;
                            if (win_cnt_q == win_last)
                            begin
                                result_o <= data_cnt_q;
                                done_o   <= 1'b1;
                                state_q  <= rfm_pkg::RFM_MEAS_IDLE;
                            end
                        end
                    end
                end
                default:
                    state_q <= rfm_pkg::RFM_MEAS_IDLE;
            endcase
        end
    end

endmodule

// File: hw/rfm_reference_clock_input_ctrl.sv
// Contract
// - In lock-to-reference mode, relock on reference after any lock loss.
// - Measurement reports data to reference ratio to one part in 10000.
// - Reference range defaults to 10-20 MHz; two-bit field selects up to 160.
// - Fine measurement never changes how data lock is acquired.
// - Fine measurement enable is a level, kept for repeated measurements.
// - Restart bit written 1 then 0 clears done flag, starts measurement; a completion in the same cycle leaves the flag set.
// - Done flag reads 0 while measuring, 1 once the result is valid.
// - 23-bit result split into high seven bits, middle and low bytes.
// - Rate readback is valid only while lock lost flag is low.
// - Nine-bit coarse rate: eight bits rate byte, LSB in status bit 0.
// - Signal lost output active high at polarity 0, active low at 1.
// - Acquisition restart bit 1 then 0 restarts; control settings kept.
// - Lock so rate over 2^ratio equals reference over 2^range.
`timescale 1ns/1ps
`include "rfm_defines.svh"

module rfm_reference_clock_input_ctrl #(
    parameter int PRESC_LOG2 = 6
) (
    // Clock and reset
    input  wire logic                   ref_clk_i,
    input  wire logic                   srst_i,
    // Register port
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    input  wire logic [2:0]             reg_addr_i,
    input  wire logic [7:0]             reg_wdata_i,
    output logic      [7:0]             reg_rdata_o,
    // Pins
    input  wire logic                   reference_clock_input_i,
    input  wire logic                   lock_lost_flag_i,
    input  wire logic                   los_detect_i,
    output logic                        signal_lost_output_o,
    // Analog front end, same clock
    input  wire logic                   data_tick_i,
    input  wire logic [8:0]             coarse_rate_i,
    output rfm_pkg::rfm_loop_ctl_t      loop_ctl_o
);

    rfm_pkg::rfm_reference_clock_input_ctrl_t   reference_clock_input_ctrl_q;
    rfm_pkg::rfm_restart_ctrl_t  restart_ctrl_q;
    rfm_pkg::rfm_output_ctrl_t   output_ctrl_q;

    logic [2:0]                  sync1_q;
    logic [2:0]                  sync2_q;
    logic                        ref_prev_q;
    logic                        lol_prev_q;
    logic                        lock_en_prev_q;
    logic                        meas_rst_prev_q;
    logic                        acq_rst_prev_q;
    logic                        meas_done_q;
    logic                        meter_done;
    logic [`RFM_RESULT_W-1:0]    result;
    logic                        ref_tick;
    logic                        lol_s;
    logic                        los_s;
    logic                        lol_rise;
    logic                        meas_fall;
    logic                        acq_fall;
    logic                        meter_en;
    logic [7:0]                  misc;

    // Pin synchronisers: 0 reference clock, 1 lock lost, 2 signal lost
    logic [2:0] pins;
    assign pins = {los_detect_i, lock_lost_flag_i, reference_clock_input_i};

    for (genvar i = 0; i < 3; i++)
    begin : g_sync
        always_ff @(posedge ref_clk_i)
        begin
            if (srst_i)
            begin
                sync1_q[i] <= 1'b0;
                sync2_q[i] <= 1'b0;
            end
            else
            begin
                sync1_q[i] <= pins[i];
                sync2_q[i] <= sync1_q[i];
            end
        end
    end

    assign lol_s     = sync2_q[1];
    assign los_s     = sync2_q[2];
    assign ref_tick  = sync2_q[0] & ~ref_prev_q;
    assign lol_rise  = lol_s & ~lol_prev_q;
    assign meas_fall = meas_rst_prev_q
                       & ~restart_ctrl_q.meas_restart;
    assign acq_fall = acq_rst_prev_q & ~restart_ctrl_q.acq_restart;
    // Both enables set is undefined; measuring is then held off
    assign meter_en  = reference_clock_input_ctrl_q.fine_en
                       & ~reference_clock_input_ctrl_q.lock_en;
    assign misc = {5'h00, meas_done_q, lol_s, coarse_rate_i[0]};

    // Control registers; software writes only these
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            reference_clock_input_ctrl_q  <= `RFM_REFERENCE_CLOCK_INPUT_CTRL_RST;
            restart_ctrl_q <= `RFM_RESTART_CTRL_RST;
            output_ctrl_q  <= `RFM_OUTPUT_CTRL_RST;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                `RFM_ADDR_REFERENCE_CLOCK_INPUT_CTRL:  reference_clock_input_ctrl_q  <= reg_wdata_i;
                `RFM_ADDR_RESTART_CTRL: restart_ctrl_q <= reg_wdata_i;
                `RFM_ADDR_OUTPUT_CTRL:  output_ctrl_q  <= reg_wdata_i;
                default:                ;
            endcase
        end
    end

    // Edge history
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            ref_prev_q      <= 1'b0;
            lol_prev_q      <= 1'b0;
            lock_en_prev_q  <= 1'b0;
            meas_rst_prev_q <= 1'b0;
            acq_rst_prev_q  <= 1'b0;
        end
        else
        begin
            ref_prev_q      <= sync2_q[0];
            lol_prev_q      <= lol_s;
            lock_en_prev_q  <= reference_clock_input_ctrl_q.lock_en;
            meas_rst_prev_q <= restart_ctrl_q.meas_restart;
            acq_rst_prev_q  <= restart_ctrl_q.acq_restart;
        end
    end

    // Loop controls; fine enable deliberately plays no part here
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            loop_ctl_o <= '0;
        else
        begin
            loop_ctl_o.lock_mode <= reference_clock_input_ctrl_q.lock_en;
            loop_ctl_o.range     <= reference_clock_input_ctrl_q.range;
            loop_ctl_o.ratio     <= reference_clock_input_ctrl_q.ratio;
            loop_ctl_o.lock_cmd  <= reference_clock_input_ctrl_q.lock_en
                                    & (~lock_en_prev_q | lol_rise);
            loop_ctl_o.acq_start <= acq_fall;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            signal_lost_output_o <= 1'b0;
        else
            signal_lost_output_o <= los_s ^ output_ctrl_q.los_pol;
    end

    // Completion wins over a restart landing in the same cycle
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            meas_done_q <= 1'b0;
        else if (meter_done)
            meas_done_q <= 1'b1;
        else if (meas_fall)
            meas_done_q <= 1'b0;
    end

    // Meter holds its result until the next window ends
    rfm_rate_meter #(
        .PRESC_LOG2 (PRESC_LOG2)
    ) u_meter (
        .clk_i       (ref_clk_i),
        .srst_i      (srst_i),
        .en_i        (meter_en),
        .start_i     (meas_fall),
        .range_i     (reference_clock_input_ctrl_q.range),
        .ref_tick_i  (ref_tick),
        .data_tick_i (data_tick_i),
        .done_o      (meter_done),
        .result_o    (result)
    );

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                `RFM_ADDR_RESULT_HIGH:
                    reg_rdata_o <= {1'b0,
                        result[`RFM_HIGH_MSB:`RFM_HIGH_LSB]};
                `RFM_ADDR_RESULT_MID:
                    reg_rdata_o <= result[`RFM_HIGH_LSB-1:`RFM_MID_LSB];
                `RFM_ADDR_RESULT_LOW:   reg_rdata_o <= result[7:0];
                `RFM_ADDR_RATE:         reg_rdata_o <= coarse_rate_i[8:1];
                `RFM_ADDR_MISC:         reg_rdata_o <= misc;
                `RFM_ADDR_REFERENCE_CLOCK_INPUT_CTRL:  reg_rdata_o <= reference_clock_input_ctrl_q;
                `RFM_ADDR_RESTART_CTRL: reg_rdata_o <= restart_ctrl_q;
                `RFM_ADDR_OUTPUT_CTRL:  reg_rdata_o <= output_ctrl_q;
                default:                reg_rdata_o <= 8'h00;
            endcase
        end
    end

    sequence s_lock_trigger;
        reference_clock_input_ctrl_q.lock_en && lol_rise;
    endsequence

    sequence s_acq_pulse;
        loop_ctl_o.acq_start ##1 !loop_ctl_o.acq_start;
    endsequence

    property p_relock;
        @(posedge ref_clk_i) disable iff (srst_i)
        s_lock_trigger |=> loop_ctl_o.lock_cmd;
    endproperty
    a_relock: assert property (p_relock)
        else $error("no relock after lock loss");

    property p_lock_rise;
        @(posedge ref_clk_i) disable iff (srst_i)
        $rose(reference_clock_input_ctrl_q.lock_en) |=> loop_ctl_o.lock_cmd;
    endproperty
    a_lock_rise: assert property (p_lock_rise)
        else $error("lock enable rise gave no lock command");

    property p_fine_no_lock;
        @(posedge ref_clk_i) disable iff (srst_i)
        loop_ctl_o.lock_cmd |-> $past(reference_clock_input_ctrl_q.lock_en);
    endproperty
    a_fine_no_lock: assert property (p_fine_no_lock)
        else $error("lock command without lock mode");

    property p_loop_fields;
        @(posedge ref_clk_i) disable iff (srst_i)
        $changed(reference_clock_input_ctrl_q) |=>
            loop_ctl_o[7:2] == $past(reference_clock_input_ctrl_q[7:2]);
    endproperty
    a_loop_fields: assert property (p_loop_fields)
        else $error("loop range or ratio not following register");

    property p_meas_clear;
        @(posedge ref_clk_i) disable iff (srst_i)
        meas_fall && !meter_done |=> !meas_done_q ##1
            (!meas_done_q || $past(meter_done));
    endproperty
    a_meas_clear: assert property (p_meas_clear)
        else $error("restart did not clear done flag");

    property p_done_set;
        @(posedge ref_clk_i) disable iff (srst_i)
        meter_done |=> meas_done_q && misc[`RFM_MISC_MEAS_DONE];
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("done flag not set on completion");

    property p_result_hold;
        @(posedge ref_clk_i) disable iff (srst_i)
        !meter_done |-> $stable(result);
    endproperty
    a_result_hold: assert property (p_result_hold)
        else $error("result changed without completion");

    property p_los_pol;
        @(posedge ref_clk_i) disable iff (srst_i)
        ##1 signal_lost_output_o == ($past(los_s) ^ $past(output_ctrl_q.los_pol));
    endproperty
    a_los_pol: assert property (p_los_pol)
        else $error("signal lost output polarity wrong");

    property p_acq_restart;
        @(posedge ref_clk_i) disable iff (srst_i)
        acq_fall && !reg_wr_i |=> s_acq_pulse and $stable(reference_clock_input_ctrl_q);
    endproperty
    a_acq_restart: assert property (p_acq_restart)
        else $error("acquisition restart pulse or settings wrong");

    property p_read_high;
        @(posedge ref_clk_i) disable iff (srst_i)
        reg_rd_i && reg_addr_i == `RFM_ADDR_RESULT_HIGH |=>
            reg_rdata_o == {1'b0, $past(result[22:16])};
    endproperty
    a_read_high: assert property (p_read_high)
        else $error("high result byte wrong");

endmodule

// File: tb/rfm_host.sv
`timescale 1ns/1ps
module rfm_host (
    // Register port
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic            wr_o,
    output logic            rd_o,
    output logic [2:0]      addr_o,
    output logic [7:0]      wdata_o
);
    initial
    begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 3'h0;
        wdata_o = 8'h00;
    end

    // One byte per strobe, launched just after an edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        rd_o = 1'b1;
        addr_o = a;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        d = rdata_i;
    endtask

    // Enable cleared first, so the set is always a fresh 0 to 1 edge
    task automatic lock_cfg(input logic [1:0] r, input logic [3:0] n);
        wr(3'h5, {r, n, 2'b00});
        wr(3'h5, {r, n, 2'b01});
    endtask

    // Range goes in before the fine enable, lock enable kept off
    task automatic meas_cfg(input logic [1:0] r);
        wr(3'h5, {r, 4'h0, 2'b00});
        wr(3'h5, {r, 4'h0, 2'b10});
    endtask

    task automatic meas_start;
        wr(3'h6, 8'h08);
        wr(3'h6, 8'h00);
    endtask

    function automatic longint rate(input logic [22:0] f, input longint fr,
                                    input logic [1:0] r);
        return (longint'(f) * fr) >> (14 + r);
    endfunction
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
    typedef struct {
        logic       wr;
        logic [2:0] a;
        logic [7:0] d;
        logic [7:0] exp;
    } rfm_row_t;
    logic                   ref_clk_i;
    logic                   srst_i;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [2:0]             reg_addr;
    logic [7:0]             reg_wdata;
    logic [7:0]             reg_rdata;
    logic                   ref_in;
    logic                   lock_lost_flag;
    logic                   signal_lost_output;
    logic                   sig_out;
    logic                   data_tick;
    logic [8:0]             coarse;
    rfm_pkg::rfm_loop_ctl_t loop_ctl;
    int                     err_total;
    int                     comparisons;
    logic [7:0]             v;
    logic [7:0]             b [3];
    logic                   hit;
    logic [22:0]            res;
    rfm_row_t               rows [7] = '{
        '{1'b1, 3'h7, 8'h04, 8'h04}, '{1'b1, 3'h7, 8'h00, 8'h00},
        '{1'b1, 3'h6, 8'h00, 8'h00}, '{1'b0, 3'h3, 8'h00, 8'had},
        '{1'b0, 3'h4, 8'h00, 8'h01}, '{1'b1, 3'h4, 8'hff, 8'h01},
        '{1'b1, 3'h3, 8'hff, 8'had}};

    rfm_reference_clock_input_ctrl #(.PRESC_LOG2(0)) DUT (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .reference_clock_input_i(ref_in),
        .lock_lost_flag_i(lock_lost_flag), .los_detect_i(signal_lost_output),
        .signal_lost_output_o(sig_out), .data_tick_i(data_tick),
        .coarse_rate_i(coarse), .loop_ctl_o(loop_ctl));
    rfm_host host (
        .clk_i(ref_clk_i), .rdata_i(reg_rdata), .wr_o(reg_wr), .rd_o(reg_rd),
        .addr_o(reg_addr), .wdata_o(reg_wdata));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // Reference at 100 MHz, well under half the system clock
    initial
    begin
        ref_in = 1'b0;
        forever #5 ref_in = ~ref_in;
    end
    // One data tick every 8 cycles: 5120 ticks in a 2^14 edge window
    initial
    begin
        data_tick = 1'b0;
        forever
        begin
            repeat (7) @(posedge ref_clk_i);
            #1 data_tick = 1'b1;
            @(posedge ref_clk_i);
            #1 data_tick = 1'b0;
        end
    end

    task automatic chk(input logic [22:0] got, input logic [22:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Pulses stand one cycle, so every cycle is looked at
    task automatic wait_bit(input int sel, input int lim, output logic h);
        h = 1'b0;
        repeat (lim)
        begin
            @(posedge ref_clk_i);
            #1;
            if ((sel == 0 ? loop_ctl.lock_cmd : loop_ctl.acq_start) === 1'b1)
                h = 1'b1;
        end
    endtask

    task automatic wait_done;
        int n;
        n = 0;
        v = 8'h00;
        while (v[2] !== 1'b1 && n < 30000)
        begin
            host.rd(3'h4, v);
            n++;
        end
        chk(23'(v[2]), 23'h1);
        if (v[2] !== 1'b1)
            stop_test();
    endtask

    task automatic read_result;
        for (int i = 0; i < 3; i++)
            host.rd(3'(i), b[i]);
    endtask

    initial
    begin
        srst_i = 1'b1;
        lock_lost_flag = 1'b0;
        signal_lost_output = 1'b0;
        coarse = 9'h15b;
        err_total = 0;
        comparisons = 0;
        repeat (3) @(posedge ref_clk_i);
        #1 srst_i = 1'b0;
        chk(23'(loop_ctl), 23'h0);
        chk(23'(sig_out), 23'h0);
        for (int i = 5; i < 8; i++)
        begin
            host.rd(3'(i), v);
            chk(23'(v), 23'h0);
        end
        $display("test reset done");
        foreach (rows[i])
        begin
            if (rows[i].wr)
                host.wr(rows[i].a, rows[i].d);
            host.rd(rows[i].a, v);
            chk(23'(v), 23'(rows[i].exp));
        end
        $display("test registers done");
        signal_lost_output = 1'b1;
        repeat (5) @(posedge ref_clk_i);
        #1;
        chk(23'(sig_out), 23'h1);
        host.wr(3'h7, 8'h04);
        repeat (3) @(posedge ref_clk_i);
        #1;
        chk(23'(sig_out), 23'h0);
        signal_lost_output = 1'b0;
        repeat (5) @(posedge ref_clk_i);
        #1;
        chk(23'(sig_out), 23'h1);
        host.wr(3'h7, 8'h00);
        $display("test polarity done");
        host.lock_cfg(2'b01, 4'h5);
        wait_bit(0, 6, hit);
        chk(23'(hit), 23'h1);
        chk(23'(loop_ctl[8:2]), 23'h55);
        lock_lost_flag = 1'b1;
        wait_bit(0, 10, hit);
        chk(23'(hit), 23'h1);
        host.rd(3'h4, v);
        chk(23'(v[1]), 23'h1);
        lock_lost_flag = 1'b0;
        host.wr(3'h6, 8'h20);
        host.wr(3'h6, 8'h00);
        wait_bit(1, 6, hit);
        chk(23'(hit), 23'h1);
        host.rd(3'h5, v);
        chk(23'(v), 23'h55);
        $display("test lock done");
        host.meas_cfg(2'b00);
        wait_bit(0, 6, hit);
        chk(23'(hit), 23'h0);
        host.meas_start();
        repeat (1000) @(posedge ref_clk_i);
        host.rd(3'h4, v);
        chk(23'(v[2]), 23'h0);
        // Restart in mid-run must throw the partial count away
        host.meas_start();
        wait_done();
        read_result();
        chk(23'(b[0][7]), 23'h0);
        res = {b[0][6:0], b[1], b[2]};
        chk(23'(host.rate(res, 100000000, 2'b00) / 100000),
            23'd312);
        $display("test measure done");
        host.meas_start();
        repeat (100) @(posedge ref_clk_i);
        host.rd(3'h4, v);
        chk(23'(v[2]), 23'h0);
        for (int i = 0; i < 3; i++)
        begin
            host.rd(3'(i), v);
            chk(23'(v), 23'(b[i]));
        end
        wait_done();
        read_result();
        res = {b[0][6:0], b[1], b[2]};
        chk(23'(res > 23'd5117 && res < 23'd5123), 23'h1);
        $display("test remeasure done");
        stop_test();
    end
endmodule
